// File: hdl/facu_unit.sv
/*
 * File access command unit: target/action selection, an execute trigger,
 * a byte transfer window, outcome/tally/size reporting and the interlock
 * against acquisition.
 * Assumes a single-master register port with one-cycle strobes and the
 * acquisition engine on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module facu_unit
    import facu_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Acquisition interlock
    input wire logic i_acq_start_req,
    input wire logic i_acq_active,
    output logic o_acq_start,
    output logic o_any_open,
    // Interrupt
    output logic o_irq
);
    // Object store, one byte array per object
    logic [7:0] store_mem [FACU_OBJ_COUNT][FACU_OBJ_BYTES];
    logic [7:0] win_mem [FACU_WIN_BYTES];
    logic [8:0] size_reg [FACU_OBJ_COUNT];
    logic [FACU_OBJ_COUNT-1:0] open_rd_reg, open_wr_reg;
    logic [2:0] target_reg, action_reg, work_obj_reg, work_act_reg;
    logic [1:0] access_reg, outcome_reg;
    // Access kind latched at execute so a late host write cannot change an open
    logic [1:0] work_acc_reg;
    logic [8:0] start_reg, span_reg, tally_reg, pos_reg, cnt_reg;
    logic [2:0] irq_stat_reg, irq_mask_reg, irq_event;
    logic [31:0] rdata_next;
    logic acq_start_reg, trig, fail_now;
    facu_state_t state_reg;

    // Byte within the object store or zero if off the end
    function automatic logic [7:0] obj_byte(input logic [8:0] idx, input logic [8:0] lim,
                                            input logic [7:0] val);
        obj_byte = (idx < lim) ? val : 8'h00;
    endfunction : obj_byte

    // Decoded write of a plain register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Window decode: 0x80..0xBF only, so higher addresses never alias into it
    function automatic logic win_hit(input logic [7:0] a);
        win_hit = (a[7:6] == 2'b10);
    endfunction : win_hit

    assign trig = i_wr && hit(i_addr, FACU_TRIGGER_OFS);

    // Selection registers written by software
    // Unused upper data bits are dropped; fields read back at their width
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            target_reg <= FACU_OBJ_FACTORY;
            action_reg <= FACU_ACT_OPEN;
            access_reg <= FACU_ACC_READ;
            start_reg <= 9'h000;
            span_reg <= 9'h000;
            irq_mask_reg <= FACU_IRQ_RST;
        end else if (i_clk_en && i_wr) begin
            if (hit(i_addr, FACU_TARGET_OFS)) target_reg <= i_wdata[2:0];
            if (hit(i_addr, FACU_ACTION_OFS)) action_reg <= i_wdata[2:0];
            if (hit(i_addr, FACU_ACCESS_OFS)) access_reg <= i_wdata[1:0];
            if (hit(i_addr, FACU_START_OFS)) start_reg <= i_wdata[8:0];
            if (hit(i_addr, FACU_SPAN_OFS)) span_reg <= i_wdata[8:0];
            if (hit(i_addr, FACU_IRQ_MASK_OFS)) irq_mask_reg <= i_wdata[2:0];
        end
    end

    // Failure check at execute time
    // Refused actions leave every object and the window untouched
    always_comb begin
        fail_now = 1'b0;
        if (target_reg >= 3'(FACU_OBJ_COUNT)) begin
            fail_now = 1'b1;
        end else begin
            case (action_reg)
                FACU_ACT_OPEN: fail_now = open_rd_reg[target_reg] | open_wr_reg[target_reg]
                                          | (access_reg > FACU_ACC_BOTH);
                FACU_ACT_CLOSE: fail_now = ~(open_rd_reg[target_reg] | open_wr_reg[target_reg]);
                FACU_ACT_READ: fail_now = ~open_rd_reg[target_reg];
                FACU_ACT_WRITE: fail_now = ~open_wr_reg[target_reg];
                FACU_ACT_DELETE: fail_now = open_rd_reg[target_reg] | open_wr_reg[target_reg];
                default: fail_now = 1'b1;
            endcase
        end
    end

    // Action engine: one byte per cycle for read and write
    // A busy engine drops a new trigger; the host polls the outcome first
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_reg <= FACU_ST_IDLE;
            outcome_reg <= FACU_OUT_SUCCESS;
            tally_reg <= 9'h000;
            open_rd_reg <= '0;
            open_wr_reg <= '0;
            work_obj_reg <= FACU_OBJ_FACTORY;
            work_act_reg <= FACU_ACT_OPEN;
            pos_reg <= 9'h000;
            cnt_reg <= 9'h000;
            work_acc_reg <= FACU_ACC_READ;
            irq_event <= 3'h0;
            for (int o = 0; o < FACU_OBJ_COUNT; o++) size_reg[o] <= 9'h000;
        end else if (i_clk_en) begin
            irq_event <= 3'h0;
            case (state_reg)
                FACU_ST_IDLE: begin
                    if (trig && !i_acq_active) begin
                        work_obj_reg <= target_reg;
                        work_act_reg <= action_reg;
                        pos_reg <= start_reg;
                        cnt_reg <= 9'h000;
                        work_acc_reg <= access_reg;
                        tally_reg <= 9'h000;
                        if (fail_now) begin
                            outcome_reg <= FACU_OUT_FAILURE;
                            irq_event[FACU_IRQ_FAIL] <= 1'b1;
                        end else begin
                            outcome_reg <= FACU_OUT_BUSY;
                            state_reg <= FACU_ST_MOVE;
                        end
                    end
                end
                FACU_ST_MOVE: begin
                    case (work_act_reg)
                        FACU_ACT_OPEN: begin
                            open_rd_reg[work_obj_reg] <= (work_acc_reg != FACU_ACC_WRITE);
                            open_wr_reg[work_obj_reg] <= (work_acc_reg != FACU_ACC_READ);
                            state_reg <= FACU_ST_DONE;
                        end
                        FACU_ACT_CLOSE: begin
                            open_rd_reg[work_obj_reg] <= 1'b0;
                            open_wr_reg[work_obj_reg] <= 1'b0;
                            state_reg <= FACU_ST_DONE;
                        end
                        FACU_ACT_DELETE: begin
                            size_reg[work_obj_reg] <= 9'h000;
                            state_reg <= FACU_ST_DONE;
                        end
                        FACU_ACT_READ, FACU_ACT_WRITE: begin
                            // stop at span, window end or store end
                            if (cnt_reg >= span_reg || cnt_reg >= 9'(FACU_WIN_BYTES)
                                || pos_reg >= 9'(FACU_OBJ_BYTES)
                                || (work_act_reg == FACU_ACT_READ
                                    && pos_reg >= size_reg[work_obj_reg])) begin
                                state_reg <= FACU_ST_DONE;
                            end else begin
                                // bytes pass only through the window
                                if (work_act_reg == FACU_ACT_READ) begin
                                    win_mem[cnt_reg[5:0]] <= obj_byte(pos_reg,
                                        size_reg[work_obj_reg],
                                        store_mem[work_obj_reg][pos_reg[7:0]]);
                                end else begin
                                    store_mem[work_obj_reg][pos_reg[7:0]] <= win_mem[cnt_reg[5:0]];
                                    if (pos_reg >= size_reg[work_obj_reg])
                                        size_reg[work_obj_reg] <= pos_reg + 9'h001;
                                end
                                pos_reg <= pos_reg + 9'h001;
                                cnt_reg <= cnt_reg + 9'h001;
                            end
                        end
                        default: state_reg <= FACU_ST_DONE;
                    endcase
                end
                FACU_ST_DONE: begin
                    tally_reg <= cnt_reg;
                    outcome_reg <= FACU_OUT_SUCCESS;
                    irq_event[FACU_IRQ_DONE] <= 1'b1;
                    state_reg <= FACU_ST_IDLE;
                    // Settings objects are checked only after a write that began at byte 0;
                    // pos minus count is the start, so a late host write cannot skew it
                    if (work_act_reg == FACU_ACT_WRITE && work_obj_reg <= FACU_OBJ_SLOT_ONE
                        && cnt_reg != 9'h000 && pos_reg == cnt_reg) begin
                        // older settings tag converted to own tag
                        if (store_mem[work_obj_reg][0] == FACU_SET_TAG_OLD) begin
                            store_mem[work_obj_reg][0] <= FACU_SET_TAG_OWN;
                        end else if (store_mem[work_obj_reg][0] != FACU_SET_TAG_OWN) begin
                            size_reg[work_obj_reg] <= 9'h000;
                        end else if (cnt_reg > 9'(FACU_SET_SUM_POS)
                                     && store_mem[work_obj_reg][FACU_SET_SUM_POS] != 8'h00) begin
                            store_mem[work_obj_reg][FACU_SET_SUM_POS] <= 8'h00;
                            size_reg[work_obj_reg] <= 9'(FACU_SET_SUM_POS + 1);
                        end
                    end
                end
                default: state_reg <= FACU_ST_IDLE;
            endcase
            // Host window writes; engine has priority while moving, so a host
            // write that lands during a move is lost and must be repeated
            if (i_wr && win_hit(i_addr) && state_reg != FACU_ST_MOVE) begin
                for (int b = 0; b < 4; b++)
                    win_mem[{i_addr[5:2], 2'(b)}] <= i_wdata[8*b +: 8];
            end
        end
    end

    // acquisition start held back while open, no reason shown
    // The refusal has no status bit: the host only sees no start
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            acq_start_reg <= 1'b0;
            o_any_open <= 1'b0;
        end else if (i_clk_en) begin
            acq_start_reg <= i_acq_start_req && ((open_rd_reg | open_wr_reg) == '0);
            o_any_open <= (open_rd_reg | open_wr_reg) != '0;
        end
    end
    assign o_acq_start = acq_start_reg;

    // Sticky status; set wins over write-one-to-clear
    // Bit 2 is the only trace left by a trigger refused during acquisition
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            irq_stat_reg <= FACU_IRQ_RST;
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            irq_stat_reg <= (irq_stat_reg & ~((i_wr && hit(i_addr, FACU_IRQ_STAT_OFS))
                                              ? i_wdata[2:0] : 3'h0))
                            | irq_event
                            | {trig && i_acq_active, 2'h0};
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read mux
    always_comb begin
        rdata_next = FACU_WORD_ZERO;
        if (win_hit(i_addr)) begin
            rdata_next = {win_mem[{i_addr[5:2], 2'h3}], win_mem[{i_addr[5:2], 2'h2}],
                          win_mem[{i_addr[5:2], 2'h1}], win_mem[{i_addr[5:2], 2'h0}]};
        end else begin
            case (i_addr)
                FACU_TARGET_OFS: rdata_next = {29'h0, target_reg};
                FACU_ACTION_OFS: rdata_next = {29'h0, action_reg};
                FACU_ACCESS_OFS: rdata_next = {30'h0, access_reg};
                FACU_START_OFS: rdata_next = {23'h0, start_reg};
                FACU_SPAN_OFS: rdata_next = {23'h0, span_reg};
                FACU_OUTCOME_OFS: rdata_next = {30'h0, outcome_reg};
                FACU_TALLY_OFS: rdata_next = {23'h0, tally_reg};
                FACU_SIZE_OFS: rdata_next = (target_reg < 3'(FACU_OBJ_COUNT))
                                            ? {23'h0, size_reg[target_reg]} : FACU_WORD_ZERO;
                FACU_ACQ_OFS: rdata_next = {30'h0, i_acq_active, o_any_open};
                FACU_IRQ_STAT_OFS: rdata_next = {29'h0, irq_stat_reg};
                FACU_IRQ_MASK_OFS: rdata_next = {29'h0, irq_mask_reg};
                default: rdata_next = FACU_WORD_ZERO;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    // Zero outside reads keeps a shared read bus free of stale words
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) o_rdata <= FACU_WORD_ZERO;
        else if (i_clk_en) o_rdata <= i_rd ? rdata_next : FACU_WORD_ZERO;
    end
endmodule : facu_unit

`default_nettype wire

// File: include/facu_pkg.sv
/*
 * Constants for the file access command unit: register map, field codes,
 * reset values and sizes.
 * Assumes a 32-bit plain register port and one 20 MHz clock.
 */
package facu_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] FACU_TARGET_OFS = 8'h00;
    localparam logic [7:0] FACU_ACTION_OFS = 8'h04;
    localparam logic [7:0] FACU_TRIGGER_OFS = 8'h08;
    localparam logic [7:0] FACU_ACCESS_OFS = 8'h0C;
    localparam logic [7:0] FACU_START_OFS = 8'h10;
    localparam logic [7:0] FACU_SPAN_OFS = 8'h14;
    localparam logic [7:0] FACU_OUTCOME_OFS = 8'h18;
    localparam logic [7:0] FACU_TALLY_OFS = 8'h1C;
    localparam logic [7:0] FACU_SIZE_OFS = 8'h20;
    localparam logic [7:0] FACU_ACQ_OFS = 8'h24;
    localparam logic [7:0] FACU_IRQ_STAT_OFS = 8'h28;
    localparam logic [7:0] FACU_IRQ_MASK_OFS = 8'h2C;
    localparam logic [7:0] FACU_WIN_BASE = 8'h80;
    // Transfer window and object store geometry
    localparam int FACU_WIN_WORDS = 16;
    localparam int FACU_WIN_BYTES = 64;
    localparam int FACU_OBJ_BYTES = 256;
    localparam int FACU_OBJ_COUNT = 5;
    // Target object codes
    localparam logic [2:0] FACU_OBJ_FACTORY = 3'h0;
    localparam logic [2:0] FACU_OBJ_SLOT_ZERO = 3'h1;
    localparam logic [2:0] FACU_OBJ_SLOT_ONE = 3'h2;
    localparam logic [2:0] FACU_OBJ_FREE_FORM = 3'h3;
    localparam logic [2:0] FACU_OBJ_UART = 3'h4;
    // Action codes
    localparam logic [2:0] FACU_ACT_OPEN = 3'h0;
    localparam logic [2:0] FACU_ACT_CLOSE = 3'h1;
    localparam logic [2:0] FACU_ACT_READ = 3'h2;
    localparam logic [2:0] FACU_ACT_WRITE = 3'h3;
    localparam logic [2:0] FACU_ACT_DELETE = 3'h4;
    // Open access kinds
    localparam logic [1:0] FACU_ACC_READ = 2'h0;
    localparam logic [1:0] FACU_ACC_WRITE = 2'h1;
    localparam logic [1:0] FACU_ACC_BOTH = 2'h2;
    // Outcome codes
    localparam logic [1:0] FACU_OUT_SUCCESS = 2'h0;
    localparam logic [1:0] FACU_OUT_FAILURE = 2'h1;
    localparam logic [1:0] FACU_OUT_BUSY = 2'h2;
    // Settings-set header: tag byte and checksum byte positions
    localparam logic [7:0] FACU_SET_TAG_OWN = 8'hA5;
    localparam logic [7:0] FACU_SET_TAG_OLD = 8'hA4;
    localparam int FACU_SET_SUM_POS = 1;
    // Interrupt bits
    localparam int FACU_IRQ_DONE = 0;
    localparam int FACU_IRQ_FAIL = 1;
    localparam int FACU_IRQ_ACQ_REFUSED = 2;
    localparam logic [2:0] FACU_IRQ_RST = 3'h0;
    localparam logic [31:0] FACU_WORD_ZERO = 32'h0000_0000;

    // Engine states
    typedef enum logic [1:0] {
        FACU_ST_IDLE = 2'b00,
        FACU_ST_MOVE = 2'b01,
        FACU_ST_DONE = 2'b10
    } facu_state_t;
endpackage : facu_pkg

// File: testbench/facu_unit_assertions.sv
/* Port checker for the file access command unit, bound into facu_unit.
   Assumes one clock domain and the synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module facu_unit_assertions
    import facu_pkg::*;
(
    // Clock and control
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Interlock and interrupt
    input wire logic i_acq_start_req,
    input wire logic i_acq_active,
    input wire logic o_acq_start,
    input wire logic o_any_open,
    input wire logic o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    logic [3:0] since_trig_reg;
    logic trig_ok;
    assign trig_ok = i_clk_en && i_wr && (i_addr == FACU_TRIGGER_OFS) && !i_acq_active;
    // Age of the last accepted trigger; saturates so long idle spans never wrap
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || trig_ok) begin
            since_trig_reg <= i_reset ? 4'hF : 4'h0;
        end else if (since_trig_reg != 4'hF) begin
            since_trig_reg <= since_trig_reg + 4'h1;
        end
    end
    a_gate_open:
    assert property (i_clk_en && i_acq_start_req && o_any_open ##1 o_any_open |-> !o_acq_start)
        else $error("acquisition start passed while an object is open");
    a_gate_pass:
    assert property (i_clk_en && i_acq_start_req && !o_any_open ##1 !o_any_open |-> o_acq_start)
        else $error("acquisition start lost with nothing open");
    a_start_cause:
    assert property ($rose(o_acq_start) |-> $past(i_acq_start_req))
        else $error("acquisition start without request");
    a_start_idle:
    assert property (i_clk_en && !i_acq_start_req |=> !o_acq_start)
        else $error("acquisition start without request");
    a_read_idle:
    assert property (i_clk_en && !i_rd |=> o_rdata == FACU_WORD_ZERO)
        else $error("read data not zero outside a read");
    a_flags_read:
    assert property (i_clk_en && i_rd && i_addr == FACU_ACQ_OFS |=>
        o_rdata == {30'h0, $past(i_acq_active), $past(o_any_open)})
        else $error("open and acquisition flags read wrong");
    a_open_cause:
    assert property ($changed(o_any_open) |-> since_trig_reg <= 4'h8)
        else $error("open state changed without an accepted trigger");
    a_mask_off:
    assert property (i_clk_en && i_wr && i_addr == FACU_IRQ_MASK_OFS && i_wdata[2:0] == 3'h0
        ##1 i_clk_en && !(i_wr && i_addr == FACU_IRQ_MASK_OFS) |=> !o_irq)
        else $error("interrupt high with every source masked");
    c_open: cover property ($rose(o_any_open));
    c_start: cover property ($rose(o_acq_start));
    c_irq: cover property ($rose(o_irq));
endmodule : facu_unit_assertions
bind facu_unit facu_unit_assertions u_facu_unit_assertions (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_acq_start_req(i_acq_start_req),
    .i_acq_active(i_acq_active), .o_acq_start(o_acq_start), .o_any_open(o_any_open),
    .o_irq(o_irq));
`default_nettype wire

// File: testbench/facu_host_model.sv
/* Host software model: register port master with an expected-read queue.
   Assumes the slave never stalls and reads answer one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module facu_host_model
    import facu_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Register port, master side
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    logic [31:0] exp_q[$];
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // One-cycle write; a quiet cycle follows so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
    endtask : wr
    // One-cycle read; the expected word is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_ref_clk);
        o_rd <= 1'b0;
    endtask : rd
    // target and access set by the caller first
    task automatic go(input logic [2:0] act, input int n);
        wr(FACU_ACTION_OFS, {29'h0, act});
        wr(FACU_TRIGGER_OFS, 32'h1);
        repeat (n + 4) @(posedge i_ref_clk);
    endtask : go
endmodule : facu_host_model
`default_nettype wire

// File: testbench/tb_top.sv
/* Self-checking bench for facu_unit driven by the host model.
   Assumes the package register map and one 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import facu_pkg::*;
;
    logic i_ref_clk, i_reset, i_clk_en, i_wr, i_rd, rd_taken = 1'b0;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rnd, wd[16];
    logic i_acq_start_req, i_acq_active, o_acq_start, o_any_open, o_irq;
    logic [31:0] cw[3] = '{32'h332200A4, 32'h000077A5, 32'h00000011};
    int fail_count = 0;
    int samples_checked = 0;
    facu_unit u_facu_unit (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_acq_start_req(i_acq_start_req), .i_acq_active(i_acq_active),
        .o_acq_start(o_acq_start), .o_any_open(o_any_open), .o_irq(o_irq));
    facu_host_model u_host (.i_ref_clk(i_ref_clk), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // Monitor: read data stands only in the cycle after the strobe
    always @(posedge i_ref_clk) rd_taken <= i_rd && i_clk_en;
    always @(negedge i_ref_clk) begin
        if (rd_taken === 1'b1) check(o_rdata, u_host.exp_q.pop_front());
    end
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fail_count++;
        end_sim();
    end
    initial begin
        i_reset = 1'b1;
        i_clk_en = 1'b1;
        i_acq_start_req = 1'b0;
        i_acq_active = 1'b0;
        rnd = $urandom(32'h0DAE);
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        for (int t = 0; t < FACU_OBJ_COUNT; t++) begin
            u_host.wr(FACU_TARGET_OFS, 32'(t));
            u_host.rd(FACU_SIZE_OFS, 32'h0);
        end
        u_host.wr(FACU_TALLY_OFS, rnd);
        u_host.rd(FACU_TALLY_OFS, 32'h0);
        u_host.rd(FACU_OUTCOME_OFS, 32'h0);
        u_host.rd(8'h30, 32'h0);
        $display("Test reset values done");
        u_host.wr(FACU_TARGET_OFS, {29'h0, FACU_OBJ_FREE_FORM});
        u_host.wr(FACU_ACCESS_OFS, {30'h0, FACU_ACC_BOTH});
        u_host.go(FACU_ACT_OPEN, 0);
        u_host.rd(FACU_ACQ_OFS, 32'h1);
        @(posedge i_ref_clk) i_acq_start_req <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        @(negedge i_ref_clk) check({31'h0, o_acq_start}, 32'h0);
        check({31'h0, o_any_open}, 32'h1);
        @(posedge i_ref_clk) i_acq_start_req <= 1'b0;
        u_host.go(FACU_ACT_OPEN, 0);
        u_host.rd(FACU_OUTCOME_OFS, {30'h0, FACU_OUT_FAILURE});
        u_host.rd(FACU_TALLY_OFS, 32'h0);
        $display("Test open and refusal done");
        for (int k = 0; k < FACU_WIN_WORDS; k++) begin
            wd[k] = $urandom;
            u_host.wr(FACU_WIN_BASE + 8'(4 * k), wd[k]);
        end
        u_host.wr(FACU_START_OFS, 32'h0);
        u_host.wr(FACU_SPAN_OFS, 32'h40);
        u_host.go(FACU_ACT_WRITE, 64);
        u_host.rd(FACU_OUTCOME_OFS, {30'h0, FACU_OUT_SUCCESS});
        u_host.rd(FACU_TALLY_OFS, 32'h40);
        u_host.rd(FACU_SIZE_OFS, 32'h40);
        u_host.wr(FACU_START_OFS, 32'h8);
        u_host.wr(FACU_SPAN_OFS, 32'h64);
        u_host.go(FACU_ACT_READ, 64);
        u_host.rd(FACU_TALLY_OFS, 32'h38);
        for (int k = 0; k < 14; k++) u_host.rd(FACU_WIN_BASE + 8'(4 * k), wd[k + 2]);
        $display("Test window transfer done");
        u_host.wr(FACU_IRQ_STAT_OFS, 32'h7);
        @(posedge i_ref_clk) i_acq_active <= 1'b1;
        u_host.go(FACU_ACT_CLOSE, 0);
        u_host.rd(FACU_ACQ_OFS, 32'h3);
        u_host.rd(FACU_IRQ_STAT_OFS, 32'h4);
        u_host.wr(FACU_IRQ_MASK_OFS, 32'h4);
        repeat (2) @(posedge i_ref_clk);
        @(negedge i_ref_clk) check({31'h0, o_irq}, 32'h1);
        u_host.wr(FACU_IRQ_MASK_OFS, 32'h0);
        repeat (2) @(posedge i_ref_clk);
        @(negedge i_ref_clk) check({31'h0, o_irq}, 32'h0);
        u_host.wr(FACU_IRQ_STAT_OFS, 32'h4);
        u_host.rd(FACU_IRQ_STAT_OFS, 32'h0);
        @(posedge i_ref_clk) i_acq_active <= 1'b0;
        u_host.go(FACU_ACT_CLOSE, 0);
        u_host.rd(FACU_ACQ_OFS, 32'h0);
        @(posedge i_ref_clk) i_acq_start_req <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        @(negedge i_ref_clk) check({31'h0, o_acq_start}, 32'h1);
        @(posedge i_ref_clk) i_acq_start_req <= 1'b0;
        u_host.go(FACU_ACT_DELETE, 0);
        u_host.rd(FACU_SIZE_OFS, 32'h0);
        // A write while the clock enable is low must be lost
        @(posedge i_ref_clk) i_clk_en <= 1'b0;
        u_host.wr(FACU_TARGET_OFS, 32'h0);
        @(posedge i_ref_clk) i_clk_en <= 1'b1;
        u_host.rd(FACU_TARGET_OFS, {29'h0, FACU_OBJ_FREE_FORM});
        $display("Test acquisition interlock done");
        for (int i = 0; i < 3; i++) begin
            u_host.wr(FACU_TARGET_OFS, 32'((i + 1) % 3));
            u_host.wr(FACU_ACCESS_OFS, {30'h0, FACU_ACC_WRITE});
            u_host.go(FACU_ACT_OPEN, 0);
            u_host.wr(FACU_WIN_BASE, cw[i]);
            u_host.wr(FACU_START_OFS, 32'h0);
            u_host.wr(FACU_SPAN_OFS, 32'h4);
            u_host.go(FACU_ACT_WRITE, 4);
            u_host.rd(FACU_TALLY_OFS, 32'h4);
            u_host.go(FACU_ACT_READ, 4);
            u_host.rd(FACU_OUTCOME_OFS, {30'h0, FACU_OUT_FAILURE});
            u_host.go(FACU_ACT_CLOSE, 0);
            u_host.rd(FACU_SIZE_OFS, 32'(4 - 2 * i));
        end
        // Slot one was regenerated, slot zero converted from the older tag
        for (int s = 0; s < 2; s++) begin
            u_host.wr(FACU_TARGET_OFS, {29'h0, (s == 0) ? FACU_OBJ_SLOT_ONE : FACU_OBJ_SLOT_ZERO});
            u_host.wr(FACU_ACCESS_OFS, {30'h0, FACU_ACC_READ});
            u_host.go(FACU_ACT_OPEN, 0);
            u_host.go(FACU_ACT_READ, 4);
            u_host.rd(FACU_WIN_BASE, (s == 0) ? 32'h000000A5 : 32'h332200A5);
            u_host.go(FACU_ACT_CLOSE, 0);
        end
        $display("Test settings objects done");
        repeat (4) @(posedge i_ref_clk);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
